// *** inc/apf_pkg.sv ***
/*
  Package for the programmable audio filter chain: register map, field layout,
  reset values and saturating arithmetic helpers.
  Assumes a single core clock domain and one sample strobe per sampling period.
*/
// Function
// RULE1: route samples by record, playback-to-DAC and filter-to-serial-out select bits.
// RULE2: high-pass, low-pass and equaliser sit in recording or playback path.
// RULE3: two cascaded first-order high-pass stages share one 14-bit coefficient pair.
// RULE4: each high-pass stage has its own independent enable.
// RULE5: a disabled stage or band passes its input unchanged.
// RULE6: host writes high-pass coefficients only while stages or power are off.
// RULE7: coefficient A is feed-forward gain, B is feedback term.
// RULE8: host keeps high-pass cut-off over sampling rate at least 0.0001.
// RULE9: one first-order low-pass stage with 14-bit coefficients and own enable.
// RULE10: host writes low-pass coefficients only while low-pass or power is off.
// RULE11: host keeps low-pass cut-off over sampling rate at least 0.05.
// RULE12: five equaliser bands, each with its own enable.
// RULE13: each band uses three 16-bit coefficients A, B and C.
// RULE14: host writes band coefficients only while that band or power is off.
// RULE15: host keeps band gain K between -1 and 3; -1 gives a notch.
// RULE16: host keeps band centre frequency over sampling rate below 0.497.
// RULE17: coefficients are real value times 2^13, two's complement, sign in MSB.
// RULE18: level control acts on recording path when record select is 1, else playback.
// RULE19: one sample per period: high-pass 1, high-pass 2, low-pass, bands 1 to 5.
// RULE20: high-pass output is A*(x - x_prev) + B*y_prev, saturated on overflow.
package apf_pkg;

  localparam int SAMPLE_W   = 16;
  localparam int FO_COEF_W  = 14;
  localparam int EQ_COEF_W  = 16;
  localparam int NUM_BANDS  = 5;
  localparam int COEF_FRAC  = 13;

  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_HP_COEF = 8'h08;
  localparam logic [7:0] REG_LP_COEF = 8'h0C;
  localparam logic [7:0] REG_EQ_AB   = 8'h10;
  localparam logic [7:0] REG_EQ_C    = 8'h14;
  localparam logic [7:0] REG_EQ_STEP = 8'h08;

  // control field positions
  localparam int CTRL_REC_SEL   = 0;
  localparam int CTRL_DAC_SEL   = 1;
  localparam int CTRL_SDO_SEL   = 2;
  localparam int CTRL_HP1_EN    = 3;
  localparam int CTRL_HP2_EN    = 4;
  localparam int CTRL_LP_EN     = 5;
  localparam int CTRL_EQ_EN_LSB = 6;
  localparam int CTRL_ADC_PWR   = 11;
  localparam int CTRL_FILT_PWR  = 12;
  localparam int CTRL_W         = 13;

  // status field positions
  localparam int STAT_SAMPLE_LSB = 0;
  localparam int STAT_SAT        = 16;

  // coefficient fields: A in the low half, B in the high half
  localparam int COEF_A_LSB = 0;
  localparam int COEF_B_LSB = 16;

  localparam logic [CTRL_W-1:0]    CTRL_RESET = 13'h0000;
  localparam logic [FO_COEF_W-1:0] FO_COEF_RESET = 14'h0000;
  localparam logic [EQ_COEF_W-1:0] EQ_COEF_RESET = 16'h0000;

  localparam logic signed [31:0] SAT_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] SAT_MIN = -32'sh0000_8000;

  // clip a wide signed value into one sample
  function automatic logic [SAMPLE_W-1:0] apf_sat16(input logic signed [31:0] v);
    logic [SAMPLE_W-1:0] r;
    r = v[SAMPLE_W-1:0];
    if (v > SAT_MAX) begin
      r = 16'h7FFF;
    end else if (v < SAT_MIN) begin
      r = 16'h8000;
    end
    return r;
  endfunction

  function automatic logic apf_ovf16(input logic signed [31:0] v);
    return (v > SAT_MAX) || (v < SAT_MIN);
  endfunction

endpackage

// *** hw/apf_first_order.sv ***
/*
  First-order IIR section, high-pass or low-pass by a static select.
  Assumes coefficients scaled by 2^13 and a one-cycle sample strobe.
*/
`timescale 1ns/1ps
module apf_first_order
  import apf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 en,
  input  wire logic                 low_pass,
  input  wire logic                 strobe,
  input  wire logic [FO_COEF_W-1:0] coef_a,
  input  wire logic [FO_COEF_W-1:0] coef_b,
  input  wire logic [SAMPLE_W-1:0]  x,
  output logic      [SAMPLE_W-1:0]  y,
  output logic                      sat
);

  typedef struct packed {
    logic [SAMPLE_W-1:0] x_prev;
    logic [SAMPLE_W-1:0] y_prev;
  } apf_fo_state_t;

  apf_fo_state_t st;
  apf_fo_state_t next_st;
  logic signed [31:0] diff;
  logic signed [31:0] acc;
  logic signed [31:0] fb;
  logic [SAMPLE_W-1:0] y_f;

  always_comb begin
    // low-pass sums neighbours and subtracts feedback; high-pass differences them
    diff = low_pass ? 32'(signed'(x)) + 32'(signed'(st.x_prev))
                    : 32'(signed'(x)) - 32'(signed'(st.x_prev)); // RULE20
    fb   = 32'(signed'(coef_b)) * 32'(signed'(st.y_prev));
    acc  = 32'(signed'(coef_a)) * diff + (low_pass ? -fb : fb); // RULE7
    acc  = acc >>> COEF_FRAC; // RULE17
    y_f  = apf_sat16(acc); // RULE20
    y    = en ? y_f : x; // RULE5
    sat  = en & strobe & apf_ovf16(acc);
    next_st = st;
    if (!en) begin
      // cleared so a later enable starts without a stale tail
      next_st = '0;
    end else if (strobe) begin
      next_st.x_prev = x;
      next_st.y_prev = y_f;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** hw/apf_eq_band.sv ***
/*
  One equaliser band: input plus a band-pass term built from A, B and C.
  Assumes coefficients scaled by 2^13 and a one-cycle sample strobe.
*/
`timescale 1ns/1ps
module apf_eq_band
  import apf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 en,
  input  wire logic                 strobe,
  input  wire logic [EQ_COEF_W-1:0] coef_a,
  input  wire logic [EQ_COEF_W-1:0] coef_b,
  input  wire logic [EQ_COEF_W-1:0] coef_c,
  input  wire logic [SAMPLE_W-1:0]  x,
  output logic      [SAMPLE_W-1:0]  y,
  output logic                      sat
);

  typedef struct packed {
    logic [SAMPLE_W-1:0] x1;
    logic [SAMPLE_W-1:0] x2;
    logic [SAMPLE_W-1:0] w1;
    logic [SAMPLE_W-1:0] w2;
  } apf_eq_state_t;

  apf_eq_state_t st;
  apf_eq_state_t next_st;
  logic signed [31:0] acc;
  logic signed [31:0] sum;
  logic [SAMPLE_W-1:0] w;

  always_comb begin
    acc = 32'(signed'(coef_a)) * (32'(signed'(x)) - 32'(signed'(st.x2)))
        + 32'(signed'(coef_b)) * 32'(signed'(st.w1))
        + 32'(signed'(coef_c)) * 32'(signed'(st.w2)); // RULE13
    acc = acc >>> COEF_FRAC; // RULE17
    w   = apf_sat16(acc);
    sum = 32'(signed'(x)) + 32'(signed'(w));
    y   = en ? apf_sat16(sum) : x; // RULE5
    sat = en & strobe & (apf_ovf16(acc) | apf_ovf16(sum));
    next_st = st;
    if (!en) begin
      next_st = '0;
    end else if (strobe) begin
      next_st.x1 = x;
      next_st.x2 = st.x1;
      next_st.w1 = w;
      next_st.w2 = st.w1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** hw/apf_filter_chain.sv ***
/*
  Programmable filter chain top: AHB-Lite register slave, path routing,
  two high-pass stages, one low-pass stage and five equaliser bands.
  Assumes sample strobes from the ADC decimator and serial input on CORE_CLK,
  at most one strobe per sampling period.
*/
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module apf_filter_chain
  import apf_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RESETN,
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  input  wire logic [SAMPLE_W-1:0] ADC_SAMPLE,
  input  wire logic                ADC_VALID,
  input  wire logic [SAMPLE_W-1:0] SDI_SAMPLE,
  input  wire logic                SDI_VALID,
  output logic      [SAMPLE_W-1:0] DAC_SAMPLE,
  output logic                     DAC_VALID,
  output logic      [SAMPLE_W-1:0] SDO_SAMPLE,
  output logic                     SDO_VALID,
  output logic      [SAMPLE_W-1:0] FILT_SAMPLE,
  output logic                     FILT_VALID,
  output logic                     ALC_ON_RECORD,
  output logic                     ALC_ON_PLAYBACK
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [CTRL_W-1:0]                       ctrl;
    logic [FO_COEF_W-1:0]                    hp_a;
    logic [FO_COEF_W-1:0]                    hp_b;
    logic [FO_COEF_W-1:0]                    lp_a;
    logic [FO_COEF_W-1:0]                    lp_b;
    logic [NUM_BANDS-1:0][EQ_COEF_W-1:0]     eq_a;
    logic [NUM_BANDS-1:0][EQ_COEF_W-1:0]     eq_b;
    logic [NUM_BANDS-1:0][EQ_COEF_W-1:0]     eq_c;
    logic                                    dp_write;
    logic                                    dp_read;
    logic [7:0]                              dp_addr;
    logic                                    sat_flag;
    logic [SAMPLE_W-1:0]                     last_filt;
    logic [SAMPLE_W-1:0]                     dac_sample;
    logic                                    dac_valid;
    logic [SAMPLE_W-1:0]                     sdo_sample;
    logic                                    sdo_valid;
    logic [SAMPLE_W-1:0]                     filt_sample;
    logic                                    filt_valid;
  } apf_top_state_t;

  apf_top_state_t st;
  apf_top_state_t next_st;

  logic                rst_meta;
  logic                rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control decode

  logic                 rec_sel;
  logic                 dac_sel;
  logic                 sdo_sel;
  logic                 filt_pwr;
  logic                 hp1_en;
  logic                 hp2_en;
  logic                 lp_en;
  logic [NUM_BANDS-1:0] eq_en;

  assign rec_sel  = st.ctrl[CTRL_REC_SEL];
  assign dac_sel  = st.ctrl[CTRL_DAC_SEL];
  assign sdo_sel  = st.ctrl[CTRL_SDO_SEL];
  assign filt_pwr = st.ctrl[CTRL_FILT_PWR];
  // powering the filter down collapses every stage to a pass-through
  assign hp1_en   = st.ctrl[CTRL_HP1_EN] & filt_pwr; // RULE4
  assign hp2_en   = st.ctrl[CTRL_HP2_EN] & filt_pwr; // RULE4
  assign lp_en    = st.ctrl[CTRL_LP_EN] & filt_pwr; // RULE9
  assign eq_en    = st.ctrl[CTRL_EQ_EN_LSB +: NUM_BANDS] & {NUM_BANDS{filt_pwr}}; // RULE12

  ////////////////////////////////////////////////////////////////////////////
  // filter chain

  logic [SAMPLE_W-1:0] chain_in;
  logic                chain_strobe;
  logic [SAMPLE_W-1:0] hp1_out;
  logic [SAMPLE_W-1:0] hp2_out;
  logic [NUM_BANDS:0][SAMPLE_W-1:0] eq_link;
  logic [NUM_BANDS-1:0] eq_sat;
  logic                hp1_sat;
  logic                hp2_sat;
  logic                lp_sat;

  // the filter sits in the recording path or the playback path
  assign chain_in     = rec_sel ? ADC_SAMPLE : SDI_SAMPLE; // RULE2
  assign chain_strobe = rec_sel ? ADC_VALID : SDI_VALID; // RULE1

  apf_first_order u_hp1 (
    .clk      (CORE_CLK),
    .rst_n    (rst_n),
    .en       (hp1_en),
    .low_pass (1'b0),
    .strobe   (chain_strobe),
    .coef_a   (st.hp_a),
    .coef_b   (st.hp_b),
    .x        (chain_in),
    .y        (hp1_out),
    .sat      (hp1_sat)
  ); // RULE3

  apf_first_order u_hp2 (
    .clk      (CORE_CLK),
    .rst_n    (rst_n),
    .en       (hp2_en),
    .low_pass (1'b0),
    .strobe   (chain_strobe),
    .coef_a   (st.hp_a),
    .coef_b   (st.hp_b),
    .x        (hp1_out),
    .y        (hp2_out),
    .sat      (hp2_sat)
  ); // RULE3

  apf_first_order u_lp (
    .clk      (CORE_CLK),
    .rst_n    (rst_n),
    .en       (lp_en),
    .low_pass (1'b1),
    .strobe   (chain_strobe),
    .coef_a   (st.lp_a),
    .coef_b   (st.lp_b),
    .x        (hp2_out),
    .y        (eq_link[0]),
    .sat      (lp_sat)
  ); // RULE19

  for (genvar g = 0; g < NUM_BANDS; g++) begin : g_band
    apf_eq_band u_band (
      .clk    (CORE_CLK),
      .rst_n  (rst_n),
      .en     (eq_en[g]),
      .strobe (chain_strobe),
      .coef_a (st.eq_a[g]),
      .coef_b (st.eq_b[g]),
      .coef_c (st.eq_c[g]),
      .x      (eq_link[g]),
      .y      (eq_link[g+1]),
      .sat    (eq_sat[g])
    ); // RULE19
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        ap_valid;
  logic [7:0]  ap_addr;
  logic        wr_hit;
  logic [7:0]  band_off;
  logic [31:0] rd_mux;
  logic        sat_event;
  logic        sat_clear;

  assign ap_valid  = HSEL & HTRANS[1] & HREADY;
  assign ap_addr   = HADDR[7:0];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign sat_event = hp1_sat | hp2_sat | lp_sat | (|eq_sat);

  // read mux looks at live registers so a read right after a write sees it
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (st.dp_addr == REG_CTRL) begin
      rd_mux[CTRL_W-1:0] = st.ctrl;
    end else if (st.dp_addr == REG_STATUS) begin
      rd_mux[STAT_SAMPLE_LSB +: SAMPLE_W] = st.last_filt;
      rd_mux[STAT_SAT] = st.sat_flag;
    end else if (st.dp_addr == REG_HP_COEF) begin
      rd_mux[COEF_A_LSB +: FO_COEF_W] = st.hp_a;
      rd_mux[COEF_B_LSB +: FO_COEF_W] = st.hp_b;
    end else if (st.dp_addr == REG_LP_COEF) begin
      rd_mux[COEF_A_LSB +: FO_COEF_W] = st.lp_a;
      rd_mux[COEF_B_LSB +: FO_COEF_W] = st.lp_b;
    end else begin
      for (int i = 0; i < NUM_BANDS; i++) begin
        if (st.dp_addr == 8'(REG_EQ_AB + 8'(i) * REG_EQ_STEP)) begin
          rd_mux[COEF_A_LSB +: EQ_COEF_W] = st.eq_a[i];
          rd_mux[COEF_B_LSB +: EQ_COEF_W] = st.eq_b[i];
        end
        if (st.dp_addr == 8'(REG_EQ_C + 8'(i) * REG_EQ_STEP)) begin
          rd_mux[COEF_A_LSB +: EQ_COEF_W] = st.eq_c[i];
        end
      end
    end
  end

  assign HRDATA = st.dp_read ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st   = st;
    band_off  = 8'h00;
    wr_hit    = st.dp_write;
    sat_clear = 1'b0;

    // address phase capture
    next_st.dp_write = ap_valid & HWRITE;
    next_st.dp_read  = ap_valid & ~HWRITE;
    if (ap_valid) begin
      next_st.dp_addr = ap_addr;
    end

    // data phase writes; coefficient write timing is left to software
    if (wr_hit) begin
      case (st.dp_addr)
        REG_CTRL: begin
          next_st.ctrl = HWDATA[CTRL_W-1:0];
        end
        REG_STATUS: begin
          sat_clear = HWDATA[STAT_SAT];
        end
        REG_HP_COEF: begin
          next_st.hp_a = HWDATA[COEF_A_LSB +: FO_COEF_W]; // RULE7
          next_st.hp_b = HWDATA[COEF_B_LSB +: FO_COEF_W]; // RULE7
        end
        REG_LP_COEF: begin
          next_st.lp_a = HWDATA[COEF_A_LSB +: FO_COEF_W]; // RULE9
          next_st.lp_b = HWDATA[COEF_B_LSB +: FO_COEF_W]; // RULE9
        end
        default: begin
          for (int i = 0; i < NUM_BANDS; i++) begin
            band_off = 8'(REG_EQ_AB + 8'(i) * REG_EQ_STEP);
            if (st.dp_addr == band_off) begin
              next_st.eq_a[i] = HWDATA[COEF_A_LSB +: EQ_COEF_W]; // RULE13
              next_st.eq_b[i] = HWDATA[COEF_B_LSB +: EQ_COEF_W]; // RULE13
            end
            if (st.dp_addr == 8'(band_off + 8'(REG_EQ_C - REG_EQ_AB))) begin
              next_st.eq_c[i] = HWDATA[COEF_A_LSB +: EQ_COEF_W]; // RULE13
            end
          end
        end
      endcase
    end

    // sticky saturation flag, a new event beats a clear in the same cycle
    if (sat_event) begin
      next_st.sat_flag = 1'b1;
    end else if (sat_clear) begin
      next_st.sat_flag = 1'b0;
    end

    // sample routing, one registered output per strobe
    next_st.filt_valid = chain_strobe; // RULE19
    if (chain_strobe) begin
      next_st.filt_sample = eq_link[NUM_BANDS];
      next_st.last_filt   = eq_link[NUM_BANDS];
    end

    // dac takes the filter output or bypasses it with serial input
    next_st.dac_valid = dac_sel ? chain_strobe : SDI_VALID; // RULE1
    if (dac_sel && chain_strobe) begin
      next_st.dac_sample = eq_link[NUM_BANDS];
    end else if (!dac_sel && SDI_VALID) begin
      next_st.dac_sample = SDI_SAMPLE;
    end

    // serial out takes the filter output or the raw adc sample
    next_st.sdo_valid = sdo_sel ? chain_strobe : ADC_VALID; // RULE1
    if (sdo_sel && chain_strobe) begin
      next_st.sdo_sample = eq_link[NUM_BANDS];
    end else if (!sdo_sel && ADC_VALID) begin
      next_st.sdo_sample = ADC_SAMPLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.ctrl <= CTRL_RESET;
      st.hp_a <= FO_COEF_RESET;
      st.hp_b <= FO_COEF_RESET;
      st.lp_a <= FO_COEF_RESET;
      st.lp_b <= FO_COEF_RESET;
      st.eq_a <= {NUM_BANDS{EQ_COEF_RESET}};
      st.eq_b <= {NUM_BANDS{EQ_COEF_RESET}};
      st.eq_c <= {NUM_BANDS{EQ_COEF_RESET}};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign DAC_SAMPLE      = st.dac_sample;
  assign DAC_VALID       = st.dac_valid;
  assign SDO_SAMPLE      = st.sdo_sample;
  assign SDO_VALID       = st.sdo_valid;
  assign FILT_SAMPLE     = st.filt_sample;
  assign FILT_VALID      = st.filt_valid;
  // level control follows the recording path when it carries the filter
  assign ALC_ON_RECORD   = rec_sel; // RULE18
  assign ALC_ON_PLAYBACK = ~rec_sel; // RULE18

endmodule

// *** sim/apf_host_model.sv ***
/* Bus host model: single whole-word AHB-Lite transfers for the bench.
   Assumes hready is the slave's hreadyout, on the same clock. */
`timescale 1ns/1ps
module apf_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel = 1'b0,
  output logic      [31:0] haddr = 32'h0000_0000,
  output logic      [1:0]  htrans = 2'b00,
  output logic             hwrite = 1'b0,
  output logic      [2:0]  hsize = 3'b010,
  output logic      [31:0] hwdata = 32'h0000_0000
);
  // ready and read data are taken at the edge, before that edge's updates land
  task automatic wait_rdy(output logic [31:0] d);
    int   n = 0;
    logic r;
    do begin
      @(posedge clk);
      r = hready;
      d = hrdata;
      #1;
      n++;
    end while (r !== 1'b1 && n < 16);
    if (r !== 1'b1) begin
      apf_filter_chain_tb_top.num_errors++;
      apf_filter_chain_tb_top.finish_test();
    end
  endtask
  // words go out as given: coefficients already scaled and signed
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    #1;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy(rd);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
endmodule

// *** sim/apf_filter_chain_sva.sv ***
/* Checker for the filter chain top ports.
   Assumes binding to the chain top; one clock domain. */
`timescale 1ns/1ps
module apf_filter_chain_sva
  import apf_pkg::*;
(
  input wire logic                CORE_CLK,
  input wire logic                RESETN,
  input wire logic                HSEL,
  input wire logic [31:0]         HADDR,
  input wire logic [1:0]          HTRANS,
  input wire logic                HWRITE,
  input wire logic                HREADY,
  input wire logic [31:0]         HRDATA,
  input wire logic [SAMPLE_W-1:0] ADC_SAMPLE,
  input wire logic                ADC_VALID,
  input wire logic [SAMPLE_W-1:0] SDI_SAMPLE,
  input wire logic                SDI_VALID,
  input wire logic [SAMPLE_W-1:0] DAC_SAMPLE,
  input wire logic                DAC_VALID,
  input wire logic [SAMPLE_W-1:0] SDO_SAMPLE,
  input wire logic                SDO_VALID,
  input wire logic [SAMPLE_W-1:0] FILT_SAMPLE,
  input wire logic                FILT_VALID,
  input wire logic                ALC_ON_RECORD,
  input wire logic                ALC_ON_PLAYBACK
);
  logic       rd_phase;
  logic [7:0] rd_addr;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_phase <= 1'b0;
      rd_addr  <= 8'h00;
    end else begin
      rd_phase <= HSEL && HTRANS[1] && HREADY && !HWRITE;
      rd_addr  <= HADDR[7:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  AST_ALC_EXCL: assert property (ALC_ON_PLAYBACK == !ALC_ON_RECORD)
    else $error("level control flags not complementary");
  AST_REC_TAKEN: assert property (ALC_ON_RECORD && ADC_VALID |=> FILT_VALID)
    else $error("record strobe gave no filtered sample");
  AST_PLAY_TAKEN: assert property (ALC_ON_PLAYBACK && SDI_VALID |=> FILT_VALID)
    else $error("playback strobe gave no filtered sample");
  AST_NO_STROBE: assert property (!(ALC_ON_RECORD ? ADC_VALID : SDI_VALID) |=> !FILT_VALID)
    else $error("filtered sample without a strobe");
  AST_FILT_HOLD: assert property (!FILT_VALID |-> $stable(FILT_SAMPLE))
    else $error("filtered sample moved without valid");
  AST_DAC_RAW: assert property (DAC_VALID && !FILT_VALID |->
    $past(SDI_VALID) && DAC_SAMPLE == $past(SDI_SAMPLE))
    else $error("raw dac sample wrong");
  AST_SDO_RAW: assert property (SDO_VALID && !FILT_VALID |->
    $past(ADC_VALID) && SDO_SAMPLE == $past(ADC_SAMPLE))
    else $error("raw serial out sample wrong");
  AST_RD_CTRL: assert property (rd_phase && rd_addr == REG_CTRL |->
    HRDATA[0] == ALC_ON_RECORD)
    else $error("record select readback wrong");
  AST_RD_IDLE: assert property (!rd_phase |-> HRDATA == 32'h0000_0000)
    else $error("read data outside data phase");
  cover property (ALC_ON_RECORD && ADC_VALID ##1 SDO_VALID);
  cover property (ALC_ON_PLAYBACK && SDI_VALID ##1 DAC_VALID);
  cover property (rd_phase && HRDATA != 32'h0000_0000);
endmodule

// *** sim/apf_filter_chain_tb_top.sv ***
/* Bench top: clock, reset, host model, sample driver and checks.
   Assumes the checker is bound to the chain; host model speaks the bus. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module apf_filter_chain_tb_top
  import apf_pkg::*;
;
  localparam logic [31:0] REC = 32'h0000_0001;
  localparam logic [31:0] DAC = 32'h0000_0002;
  localparam logic [31:0] SDO = 32'h0000_0004;
  localparam logic [31:0] HP1 = 32'h0000_0008;
  localparam logic [31:0] HP2 = 32'h0000_0010;
  localparam logic [31:0] LPE = 32'h0000_0020;
  localparam logic [31:0] PWR = 32'h0000_1000;
  int                num_errors = 0;
  int                checks_done = 0;
  logic              core_clk, resetn = 1'b0;
  logic              hsel, hwrite, hreadyout, hresp;
  logic              adc_valid = 1'b0, sdi_valid = 1'b0;
  logic              dac_valid, sdo_valid, filt_valid, alc_rec, alc_play;
  logic       [1:0]  htrans;
  logic       [2:0]  hsize;
  logic       [31:0] haddr, hwdata, hrdata;
  logic       [15:0] adc_sample = 16'h0000, sdi_sample = 16'h0000;
  logic       [15:0] dac_sample, sdo_sample, filt_sample;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  apf_filter_chain i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ADC_SAMPLE(adc_sample),
    .ADC_VALID(adc_valid), .SDI_SAMPLE(sdi_sample), .SDI_VALID(sdi_valid),
    .DAC_SAMPLE(dac_sample), .DAC_VALID(dac_valid), .SDO_SAMPLE(sdo_sample),
    .SDO_VALID(sdo_valid), .FILT_SAMPLE(filt_sample), .FILT_VALID(filt_valid),
    .ALC_ON_RECORD(alc_rec), .ALC_ON_PLAYBACK(alc_play));
  apf_host_model i_host (.clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    i_host.xfer({24'h00_0000, a}, 1'b1, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    i_host.xfer({24'h00_0000, a}, 1'b0, 32'h0000_0000, rd);
    `CHK(rd, e)
  endtask
  // the idle sample lines carry the inverse, so a stale capture shows
  task automatic smp(input logic adc, input logic [15:0] x, input logic [15:0] e,
                     input logic [2:0] ev);
    @(posedge core_clk);
    adc_sample <= x;
    sdi_sample <= x;
    adc_valid  <= adc;
    sdi_valid  <= !adc;
    @(posedge core_clk);
    adc_valid  <= 1'b0;
    sdi_valid  <= 1'b0;
    adc_sample <= ~x;
    sdi_sample <= ~x;
    #1;
    `CHK({filt_valid, dac_valid, sdo_valid}, ev)
    if (ev[2]) `CHK(filt_sample, e)
  endtask
  // a bypassed flush sample first, so enabled stages start from clear history
  task automatic trio(input logic m, input logic [31:0] en, input logic [15:0] e1,
                      input logic [15:0] e2, input logic [15:0] e3);
    logic [31:0] base;
    logic [2:0]  ev;
    base = m ? (REC | SDO | PWR) : (DAC | PWR);
    ev = m ? 3'b101 : 3'b110;
    wr(REG_CTRL, base);
    smp(m, 16'h0000, 16'h0000, ev);
    wr(REG_CTRL, base | en);
    smp(m, 16'h0064, e1, ev);
    smp(m, 16'h012C, e2, ev);
    smp(m, 16'h0000, e3, ev);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK({alc_play, hresp}, 2'b10)
    rdc(REG_CTRL, 32'h0000_0000);
    rdc(8'h38, 32'h0000_0000);
    wr(REG_CTRL, REC | SDO | PWR);
    `CHK(alc_rec, 1'b1)
    rdc(REG_CTRL, REC | SDO | PWR);
    smp(1'b1, 16'h1234, 16'h1234, 3'b101);
    `CHK(sdo_sample, 16'h1234)
    smp(1'b0, 16'h0246, 16'h0000, 3'b010);
    `CHK(dac_sample, 16'h0246)
    wr(REG_CTRL, DAC | PWR);
    smp(1'b0, 16'h0ABC, 16'h0ABC, 3'b110);
    smp(1'b1, 16'h0555, 16'h0000, 3'b001);
    `CHK(sdo_sample, 16'h0555)
    wr(REG_CTRL, REC | DAC | SDO | PWR);
    smp(1'b1, 16'h0321, 16'h0321, 3'b111);
    `CHK(dac_sample, 16'h0321)
    wr(REG_HP_COEF, 32'h1000_1800);
    rdc(REG_HP_COEF, 32'h1000_1800);
    trio(1'b1, HP1, 16'h004B, 16'h00BB, 16'hFF7C);
    trio(1'b1, HP2, 16'h004B, 16'h00BB, 16'hFF7C);
    trio(1'b1, HP1 | HP2, 16'h0038, 16'h0070, 16'hFF48);
    wr(REG_LP_COEF, 32'h3000_0800);
    trio(1'b0, LPE, 16'h0019, 16'h0070, 16'h0083);
    for (int n = 0; n < NUM_BANDS; n++) begin
      wr(REG_EQ_AB + 8'(8 * n), 32'h1000_2000);
      wr(REG_EQ_C + 8'(8 * n), 32'h0000_F000);
      trio(1'b1, 32'h0000_0001 << (CTRL_EQ_EN_LSB + n), 16'h00C8, 16'h028A, 16'h0019);
    end
    smp(1'b1, 16'h7000, 16'h7FFF, 3'b101);
    rdc(REG_STATUS, 32'h0001_7FFF);
    wr(REG_STATUS, 32'h0001_0000);
    rdc(REG_STATUS, 32'h0000_7FFF);
    wr(REG_CTRL, REC | SDO | HP1);
    smp(1'b1, 16'h0100, 16'h0100, 3'b101);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
endmodule
bind apf_filter_chain apf_filter_chain_sva i_sva (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .ADC_SAMPLE(ADC_SAMPLE), .ADC_VALID(ADC_VALID),
  .SDI_SAMPLE(SDI_SAMPLE), .SDI_VALID(SDI_VALID), .DAC_SAMPLE(DAC_SAMPLE),
  .DAC_VALID(DAC_VALID), .SDO_SAMPLE(SDO_SAMPLE), .SDO_VALID(SDO_VALID),
  .FILT_SAMPLE(FILT_SAMPLE), .FILT_VALID(FILT_VALID), .ALC_ON_RECORD(ALC_ON_RECORD),
  .ALC_ON_PLAYBACK(ALC_ON_PLAYBACK));
